//--- sleep_ctrl.sv
/*
 * sleep-mode and clock-gating controller: takes the sleep instruction,
 * picks the clock domains and oscillators to stop, filters wake sources,
 * times the wake-up, gates peripheral clocks and steers analog power.
 * assumes core and wake sources are on REF_CLK except the pins, which are
 * synchronised here; strobe register port with read data one cycle later.
 */
`default_nettype none

// Summary of operation
// - sleep needs enable bit plus sleep instruction
// - interrupt wake halts core four extra cycles
// - idle stops only cpu and flash clocks
// - adc noise mode also stops io clock
// - enabled converter starts conversion on adc noise entry
// - adc noise mode wake source set
// - power-down stops oscillator and generated clocks
// - power-down wake source set
// - power-down wake waits fuse start-up period
// - power-save keeps timer2 and display running
// - power-save timer2 wake needs mask and global enable
// - power-save stops unused oscillator and main clock
// - standby keeps oscillator, wakes in six cycles
// - gate bit stops clock and blocks registers
// - clearing gate resumes frozen state
// - gating matters only in active and idle
// - converter stays on; reenable needs extended conversion
// - comparator auto-off in deep modes unless reference
// - brown-out and watchdog stay enabled in sleep
// - reference powered only while a user needs it
// - input buffers off when io and adc clocks stop
// - debug keeps main clock in deep sleep
// - disable bit or fuse turns test port off
module sleep_ctrl
    import sleep_ctrl_pkg::*;
#(
    parameter int unsigned STARTUP_LEN = STARTUP_CYCLES,
    parameter int unsigned NUM_GATES = GATE_W
)
(
    // clock and reset
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // core
    input wire logic SLEEP_INSTR,
    input wire logic GLOBAL_IRQ_EN,
    output logic CORE_HALT,
    output logic WAKE_IRQ,
    // wake sources, same clock
    input wire wake_src_t WAKE_IN,
    input wire logic [1:0] TIMER2_INTERRUPT_MASK,
    // wake pins from outside
    input wire logic EXTERNAL_INTERRUPT_ZERO_PIN_LEVEL,
    input wire logic PIN_CHANGE_PIN,
    // peripheral status
    input wire logic CONV_ENABLED,
    input wire logic COMP_ENABLED,
    input wire logic COMP_USES_REF,
    input wire logic BOD_ENABLED,
    input wire logic WDT_ENABLED,
    input wire logic T2_ASYNC,
    input wire logic T2_ENABLED,
    input wire logic DISP_ASYNC,
    input wire logic DISP_ENABLED,
    // fuses
    input wire logic CRYSTAL_CLOCK_FUSE,
    input wire logic DEBUG_ENABLE_FUSE,
    input wire logic TEST_PORT_ENABLE_FUSE,
    // clock and power controls
    output clk_en_t CLK_EN,
    output logic [NUM_GATES-1:0] PERIPH_CLK_EN,
    output logic [NUM_GATES-1:0] PERIPH_REG_ACCESS,
    output logic CONV_START,
    output logic CONV_EXTENDED,
    output logic COMP_POWER,
    output logic BOD_POWER,
    output logic WDT_POWER,
    output logic REF_POWER,
    output logic INPUT_BUF_EN,
    output logic TEST_PORT_EN
);

    initial
    begin
        if (NUM_GATES < 1 || NUM_GATES > 8)
            $error("NUM_GATES must be 1 to 8");
        if (STARTUP_LEN < 1)
            $error("STARTUP_LEN must be at least 1");
    end

    function automatic logic mode_valid(input logic [2:0] m);
        return m == SM_IDLE || m == SM_ADC_NR || m == SM_PDOWN || m == SM_PSAVE ||
            m == SM_STANDBY;
    endfunction

    function automatic logic deep_mode(input logic [2:0] m);
        return m == SM_PDOWN || m == SM_PSAVE || m == SM_STANDBY;
    endfunction

    logic [7:0] sleep_ctrl_reg;
    logic [7:0] gate_reg;
    logic [7:0] mcu_ctrl_reg;
    sleep_state_t state;
    logic [2:0] cur_mode;
    logic [31:0] wait_cnt;
    logic external_interrupt_zero_s1, external_interrupt_zero_s2, pc_s1, pc_s2;
    logic conv_was_en;
    logic conv_need_ext;
    logic wake;
    logic wake_by_irq;
    logic wake_by_reset;
    logic asleep;
    logic [2:0] sel_mode;
    logic sleep_req;
    logic t2_wake;
    logic test_on;

    assign sel_mode = sleep_ctrl_reg[SM_LSB +: SM_W];
    // a reserved code, or standby without the crystal option, leaves the request unheeded
    assign sleep_req = SLEEP_INSTR && sleep_ctrl_reg[SE_POS] && mode_valid(sel_mode) &&
        (sel_mode != SM_STANDBY || CRYSTAL_CLOCK_FUSE);
    assign asleep = state == ST_SLEEP;

    // pins cross in through two flops; only the second is read
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            external_interrupt_zero_s1 <= 1'b0;
            external_interrupt_zero_s2 <= 1'b0;
            pc_s1 <= 1'b0;
            pc_s2 <= 1'b0;
        end
        else
        begin
            external_interrupt_zero_s1 <= EXTERNAL_INTERRUPT_ZERO_PIN_LEVEL;
            external_interrupt_zero_s2 <= external_interrupt_zero_s1;
            pc_s1 <= PIN_CHANGE_PIN;
            pc_s2 <= pc_s1;
        end
    end

    // a held level is seen only once it survives the synchroniser
    assign t2_wake = GLOBAL_IRQ_EN &&
        ((WAKE_IN.t2_ovf && TIMER2_INTERRUPT_MASK[0]) ||
        (WAKE_IN.t2_cmp && TIMER2_INTERRUPT_MASK[1]));
    assign wake_by_reset = WAKE_IN.ext_reset || WAKE_IN.wdt_reset || WAKE_IN.bod_reset;

    always_comb
    begin
        wake_by_irq = 1'b0;
        case (cur_mode)
            SM_IDLE:
                wake_by_irq = |WAKE_IN || external_interrupt_zero_s2 || pc_s2;
            SM_ADC_NR:
                wake_by_irq = WAKE_IN.conv_done || WAKE_IN.disp_irq || WAKE_IN.start_cond ||
                    WAKE_IN.t2_ovf || WAKE_IN.t2_cmp || WAKE_IN.store_ready ||
                    external_interrupt_zero_s2 || pc_s2;
            SM_PSAVE:
                wake_by_irq = WAKE_IN.start_cond || external_interrupt_zero_s2 || pc_s2 || t2_wake ||
                    WAKE_IN.disp_irq;
            default:
                wake_by_irq = WAKE_IN.start_cond || external_interrupt_zero_s2 || pc_s2;
        endcase
    end
    assign wake = wake_by_irq || wake_by_reset;

    // sleep sequencer
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state <= ST_RUN;
            cur_mode <= SM_IDLE;
            wait_cnt <= 32'h0;
            WAKE_IRQ <= 1'b0;
        end
        else
        begin
            WAKE_IRQ <= 1'b0;
            case (state)
                ST_RUN:
                    if (sleep_req)
                    begin
                        state <= ST_SLEEP;
                        cur_mode <= sel_mode;
                    end
                ST_SLEEP:
                    if (wake)
                    begin
                        state <= ST_STARTUP;
                        if (cur_mode == SM_STANDBY)
                            wait_cnt <= STANDBY_WAKE_CYCLES - 1;
                        else if (deep_mode(cur_mode))
                            wait_cnt <= STARTUP_LEN - 1;
                        else
                            wait_cnt <= 32'h0;
                    end
                ST_STARTUP:
                    if (wait_cnt != 32'h0)
                        wait_cnt <= wait_cnt - 32'h1;
                    else
                    begin
                        state <= ST_HALT;
                        wait_cnt <= WAKE_HALT_CYCLES - 1;
                    end
                default:
                    if (wait_cnt != 32'h0)
                        wait_cnt <= wait_cnt - 32'h1;
                    else
                    begin
                        state <= ST_RUN;
                        WAKE_IRQ <= 1'b1;
                    end
            endcase
        end
    end

    assign CORE_HALT = state != ST_RUN;

    // clock domains per mode
    always_comb
    begin
        CLK_EN = '1;
        if (state != ST_RUN)
        begin
            CLK_EN.cpu = 1'b0;
            CLK_EN.flash = 1'b0;
            if (cur_mode != SM_IDLE)
                CLK_EN.io = 1'b0;
            if (deep_mode(cur_mode))
            begin
                CLK_EN.adc = 1'b0;
                CLK_EN.asy = 1'b0;
                CLK_EN.timer_osc = 1'b0;
                CLK_EN.main_osc = cur_mode == SM_STANDBY;
                if (cur_mode == SM_PSAVE)
                begin
                    // sync clock here feeds only timer2 and display
                    CLK_EN.asy = (T2_ENABLED && T2_ASYNC) || (DISP_ENABLED && DISP_ASYNC);
                    CLK_EN.timer_osc = CLK_EN.asy;
                    CLK_EN.main_osc = (T2_ENABLED && !T2_ASYNC) ||
                        (DISP_ENABLED && !DISP_ASYNC);
                end
                if (DEBUG_ENABLE_FUSE && test_on)
                    CLK_EN.main_osc = 1'b1;
            end
        end
    end

    // deep modes already stop the clocks, so gates only add in run and idle
    always_comb
    begin
        for (int i = 0; i < NUM_GATES; i++)
        begin
            PERIPH_CLK_EN[i] = !gate_reg[i] && CLK_EN.io;
            PERIPH_REG_ACCESS[i] = !gate_reg[i];
        end
    end

    // converter stays powered; remember an off-on for an extended conversion
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            conv_was_en <= 1'b0;
            conv_need_ext <= 1'b1;
            CONV_START <= 1'b0;
        end
        else
        begin
            conv_was_en <= CONV_ENABLED;
            CONV_START <= sleep_req && sel_mode == SM_ADC_NR && CONV_ENABLED;
            if (CONV_ENABLED && !conv_was_en)
                conv_need_ext <= 1'b1;
            else if (CONV_START)
                conv_need_ext <= 1'b0;
        end
    end
    assign CONV_EXTENDED = conv_need_ext;

    assign COMP_POWER = COMP_ENABLED &&
        (!asleep || !deep_mode(cur_mode) || COMP_USES_REF);
    assign BOD_POWER = BOD_ENABLED;
    assign WDT_POWER = WDT_ENABLED;
    assign REF_POWER = BOD_ENABLED || (COMP_POWER && COMP_USES_REF) ||
        CONV_ENABLED;
    // wake pins keep their own buffers on the far side
    assign INPUT_BUF_EN = CLK_EN.io || CLK_EN.adc;
    assign test_on = TEST_PORT_ENABLE_FUSE && !mcu_ctrl_reg[TEST_DIS_POS];
    assign TEST_PORT_EN = test_on;

    // register writes
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            sleep_ctrl_reg <= CTRL_RESET;
            gate_reg <= GATE_RESET;
            mcu_ctrl_reg <= MCU_RESET;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == SLEEP_CTRL_OFS)
                sleep_ctrl_reg <= {4'h0, REG_WDATA[3:0]};
            else if (REG_ADDR == GATE_OFS)
                gate_reg <= REG_WDATA & 8'((1 << NUM_GATES) - 1);
            else if (REG_ADDR == MCU_CTRL_OFS)
                mcu_ctrl_reg <= REG_WDATA & 8'(1 << TEST_DIS_POS);
        end
    end

    // register reads, unmapped reads zero
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            REG_RDATA <= 8'h00;
        else if (!REG_RD)
            REG_RDATA <= 8'h00;
        else if (REG_ADDR == SLEEP_CTRL_OFS)
            REG_RDATA <= sleep_ctrl_reg;
        else if (REG_ADDR == GATE_OFS)
            REG_RDATA <= gate_reg;
        else if (REG_ADDR == MCU_CTRL_OFS)
            REG_RDATA <= mcu_ctrl_reg;
        else if (REG_ADDR == STATUS_OFS)
            REG_RDATA <= {4'h0, conv_need_ext, cur_mode};
        else
            REG_RDATA <= 8'h00;
    end

    sequence halt_four_s;
        state == ST_HALT [*4] ##1 state == ST_RUN;
    endsequence

    property halt_prop;
        @(posedge REF_CLK) disable iff (SYS_RST)
        $rose(state == ST_HALT) |-> halt_four_s;
    endproperty

    wake_halt_a: assert property (halt_prop)
        else $error("wake halt not four cycles");

    sleep_entry_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        state == ST_RUN && SLEEP_INSTR && !sleep_ctrl_reg[SE_POS] |=> state == ST_RUN)
        else $error("slept without enable bit");

    reserved_mode_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        state == ST_RUN && SLEEP_INSTR && !mode_valid(sel_mode) |=> state == ST_RUN)
        else $error("reserved mode entered sleep");

    idle_clocks_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        asleep && cur_mode == SM_IDLE |-> !CLK_EN.cpu && CLK_EN.io && CLK_EN.adc)
        else $error("idle clock set wrong");

    adc_noise_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        asleep && cur_mode == SM_ADC_NR |-> !CLK_EN.io && CLK_EN.adc)
        else $error("adc noise clocks wrong");

    conv_start_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        sleep_req && sel_mode == SM_ADC_NR && CONV_ENABLED |=> CONV_START)
        else $error("no conversion on entry");

    standby_wake_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        asleep && cur_mode == SM_STANDBY && wake |=> state == ST_STARTUP [*6] ##1
        state == ST_HALT)
        else $error("standby wake not six cycles");

    pdown_osc_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        asleep && cur_mode == SM_PDOWN && !(DEBUG_ENABLE_FUSE && test_on) |->
        !CLK_EN.main_osc && !CLK_EN.adc)
        else $error("power-down clock running");

    gate_stop_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        REG_WR && REG_ADDR == GATE_OFS && REG_WDATA[0] |=> !PERIPH_CLK_EN[0])
        else $error("gated clock still running");

    comp_off_a: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        asleep && cur_mode == SM_PDOWN && !COMP_USES_REF |-> !COMP_POWER)
        else $error("comparator on in deep sleep");

endmodule

`default_nettype wire

//--- sleep_ctrl_pkg.sv
/*
 * package for the sleep and clock-gating controller: register offsets,
 * field positions, reset values, mode codes and timing constants.
 * assumes a single 20 MHz system clock and a plain strobe register port.
 */
`default_nettype none

package sleep_ctrl_pkg;

    localparam int unsigned REF_CLK_HZ = 20_000_000;

    // register map, byte offsets on the plain port
    localparam logic [7:0] SLEEP_CTRL_OFS = 8'h00;
    localparam logic [7:0] GATE_OFS = 8'h04;
    localparam logic [7:0] MCU_CTRL_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0c;

    // register fields, widths and reset values
    localparam int SE_POS = 0;
    localparam int SM_LSB = 1;
    localparam int SM_W = 3;
    localparam int TEST_DIS_POS = 7;
    localparam int GATE_W = 5;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] GATE_RESET = 8'h00;
    localparam logic [7:0] MCU_RESET = 8'h00;

    // mode select encodings
    localparam logic [2:0] SM_IDLE = 3'h0;
    localparam logic [2:0] SM_ADC_NR = 3'h1;
    localparam logic [2:0] SM_PDOWN = 3'h2;
    localparam logic [2:0] SM_PSAVE = 3'h3;
    localparam logic [2:0] SM_STANDBY = 3'h6;

    // timing
    localparam int unsigned WAKE_HALT_CYCLES = 4;
    localparam int unsigned STANDBY_WAKE_CYCLES = 6;
    localparam int unsigned STARTUP_US = 4100;
    localparam int unsigned STARTUP_CYCLES = STARTUP_US * (REF_CLK_HZ / 1_000_000);

    typedef enum {ST_RUN, ST_SLEEP, ST_STARTUP, ST_HALT} sleep_state_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic asy;
        logic main_osc;
        logic timer_osc;
    } clk_en_t;

    typedef struct packed {
        logic conv_done;
        logic ext_reset;
        logic wdt_reset;
        logic bod_reset;
        logic disp_irq;
        logic start_cond;
        logic t2_ovf;
        logic t2_cmp;
        logic store_ready;
        logic external_interrupt_zero_level;
        logic pin_change;
        logic other_io;
    } wake_src_t;

endpackage

`default_nettype wire

//--- wake_partner.sv
/*
 * model of the wake side: core-side peripherals and the two wake pins.
 * assumes the bench sets a pattern, raises arm and keeps it up until the core runs.
 */
`default_nettype none

module wake_partner
    import sleep_ctrl_pkg::*;
#(
    parameter int DELAY = 3
)
(
    // clock
    input wire logic clk,
    // control from the bench
    input wire logic arm,
    input wire wake_src_t pattern,
    // toward the controller
    output wake_src_t wake,
    output logic external_interrupt_zero_pin,
    output logic pin_chg
);
    timeunit 1ns;
    timeprecision 1ns;

    logic live = 1'b0;
    int cnt = 0;

    // a level source stays up while armed, so a slow wake-up still sees it
    always @(posedge clk)
    begin
        cnt <= arm ? cnt + 1 : 0;
        live <= arm && cnt >= DELAY;
    end

    // pins travel only on the pin wires, never on the same-clock bundle
    assign wake = live ? wake_src_t'(pattern & ~12'h006) : wake_src_t'(12'h000);
    assign external_interrupt_zero_pin = live & pattern.external_interrupt_zero_level;
    assign pin_chg = live & pattern.pin_change;
endmodule

`default_nettype wire

//--- testbench.sv
/*
 * self-checking bench for the sleep controller: register port, every sleep
 * mode with an accepted wake source, all but idle also a refused one, gating and power steering.
 * assumes a 20 MHz clock and the start-up count shortened to 8 cycles.
 */
`default_nettype none

module testbench
    import sleep_ctrl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct {logic [2:0] m; logic [11:0] w, b; logic [6:0] c; int n; logic d;} row_t;
    // wait counts: 1 + start-up + 4 halt cycles, pins add 2 sync cycles
    // the last row is power-save with timer2 on the sync clock
    row_t rows[7] = '{'{3'h0, 12'h001, 12'h000, 7'h1f, 6, 1'b0},
        '{3'h1, 12'h800, 12'h001, 7'h0f, 6, 1'b0}, '{3'h2, 12'h040, 12'h800, 7'h00, 13, 1'b0},
        '{3'h3, 12'h020, 12'h020, 7'h05, 13, 1'b0}, '{3'h6, 12'h002, 12'h020, 7'h02, 13, 1'b0},
        '{3'h2, 12'h004, 12'h000, 7'h02, 15, 1'b1},
        '{3'h3, 12'h020, 12'h020, 7'h02, 13, 1'b0}};
    logic [7:0] ra[5] = '{SLEEP_CTRL_OFS, GATE_OFS, MCU_CTRL_OFS, STATUS_OFS, 8'h10};
    logic [7:0] rv[5] = '{CTRL_RESET, GATE_RESET, MCU_RESET, 8'h08, 8'h00};
    logic [7:0] refused[4] = '{8'h00, 8'h09, 8'h0b, 8'h0f};

    logic REF_CLK = 1'b0, SYS_RST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
    logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
    logic SLEEP_INSTR = 1'b0, GLOBAL_IRQ_EN = 1'b1, arm = 1'b0;
    logic CONV_ENABLED = 1'b1, COMP_ENABLED = 1'b1, COMP_USES_REF = 1'b0;
    logic BOD_ENABLED = 1'b1, WDT_ENABLED = 1'b1, DEBUG_ENABLE_FUSE = 1'b0;
    logic TEST_PORT_ENABLE_FUSE = 1'b1;
    logic T2_ASYNC = 1'b1, DISP_ENABLED = 1'b0, CRYSTAL_CLOCK_FUSE = 1'b1, INPUT_BUF_EN;
    wake_src_t pat = wake_src_t'(12'h000);
    wake_src_t WAKE_IN;
    clk_en_t CLK_EN;
    logic [7:0] REG_RDATA;
    logic [4:0] PERIPH_CLK_EN, PERIPH_REG_ACCESS;
    logic CORE_HALT, WAKE_IRQ, EXTERNAL_INTERRUPT_ZERO_PIN_LEVEL, PIN_CHANGE_PIN, CONV_START, CONV_EXTENDED;
    logic COMP_POWER, BOD_POWER, WDT_POWER, REF_POWER, TEST_PORT_EN;
    int bad_count = 0;
    int checks = 0;

    sleep_ctrl #(.STARTUP_LEN(8)) sleep_ctrl_i (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .SLEEP_INSTR(SLEEP_INSTR), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
        .CORE_HALT(CORE_HALT), .WAKE_IRQ(WAKE_IRQ), .WAKE_IN(WAKE_IN),
        .TIMER2_INTERRUPT_MASK(2'b01), .EXTERNAL_INTERRUPT_ZERO_PIN_LEVEL(EXTERNAL_INTERRUPT_ZERO_PIN_LEVEL),
        .PIN_CHANGE_PIN(PIN_CHANGE_PIN), .CONV_ENABLED(CONV_ENABLED),
        .COMP_ENABLED(COMP_ENABLED), .COMP_USES_REF(COMP_USES_REF),
        .BOD_ENABLED(BOD_ENABLED), .WDT_ENABLED(WDT_ENABLED), .T2_ASYNC(T2_ASYNC),
        .T2_ENABLED(1'b1), .DISP_ASYNC(1'b0), .DISP_ENABLED(DISP_ENABLED),
        .CRYSTAL_CLOCK_FUSE(CRYSTAL_CLOCK_FUSE), .DEBUG_ENABLE_FUSE(DEBUG_ENABLE_FUSE),
        .TEST_PORT_ENABLE_FUSE(TEST_PORT_ENABLE_FUSE), .CLK_EN(CLK_EN),
        .PERIPH_CLK_EN(PERIPH_CLK_EN), .PERIPH_REG_ACCESS(PERIPH_REG_ACCESS),
        .CONV_START(CONV_START), .CONV_EXTENDED(CONV_EXTENDED), .COMP_POWER(COMP_POWER),
        .BOD_POWER(BOD_POWER), .WDT_POWER(WDT_POWER), .REF_POWER(REF_POWER),
        .INPUT_BUF_EN(INPUT_BUF_EN), .TEST_PORT_EN(TEST_PORT_EN));

    wake_partner wake_partner_i (.clk(REF_CLK), .arm(arm), .pattern(pat),
        .wake(WAKE_IN), .external_interrupt_zero_pin(EXTERNAL_INTERRUPT_ZERO_PIN_LEVEL), .pin_chg(PIN_CHANGE_PIN));

    initial
    begin
        forever #25 REF_CLK = ~REF_CLK;
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge REF_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1;
        chk(REG_RDATA, exp);
    endtask

    task automatic slp(input logic d);
        @(posedge REF_CLK);
        SLEEP_INSTR <= 1'b1;
        DEBUG_ENABLE_FUSE <= d;
        @(posedge REF_CLK);
        SLEEP_INSTR <= 1'b0;
        #1;
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // the whole run is well under a thousand cycles
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        bad_count++;
        results();
    end

    initial
    begin
        row_t r;
        int n;
        repeat (12) @(posedge REF_CLK);
        SYS_RST <= 1'b0;
        foreach (ra[i])
            rd(ra[i], rv[i]);
        chk({CLK_EN, CORE_HALT, CONV_EXTENDED}, 9'h1fd);
        $display("done: reset");
        foreach (refused[i])
        begin
            wr(SLEEP_CTRL_OFS, refused[i]);
            slp(1'b0);
            chk(CORE_HALT, 1'b0);
        end
        // standby code without the crystal option must not sleep
        CRYSTAL_CLOCK_FUSE <= 1'b0;
        wr(SLEEP_CTRL_OFS, 8'h0d);
        slp(1'b0);
        chk(CORE_HALT, 1'b0);
        CRYSTAL_CLOCK_FUSE <= 1'b1;
        wr(SLEEP_CTRL_OFS, 8'hff);
        rd(SLEEP_CTRL_OFS, 8'h0f);
        chk(TEST_PORT_EN, 1'b1);
        wr(MCU_CTRL_OFS, 8'h80);
        chk(TEST_PORT_EN, 1'b0);
        wr(MCU_CTRL_OFS, 8'h00);
        $display("done: refused sleep");
        foreach (rows[i])
        begin
            r = rows[i];
            T2_ASYNC <= i != 6;
            wr(SLEEP_CTRL_OFS, {4'h0, r.m, 1'b1});
            slp(r.d);
            chk(CORE_HALT, 1'b1);
            chk(CONV_START, r.m == SM_ADC_NR);
            chk(CLK_EN, r.c);
            chk(COMP_POWER, r.m < 3'h2);
            chk(INPUT_BUF_EN, r.m < 3'h2);
            chk({BOD_POWER, WDT_POWER}, 2'b11);
            // psave refuses a timer wake while interrupts are globally off
            @(posedge REF_CLK);
            pat <= r.b;
            arm <= r.b != 0;
            GLOBAL_IRQ_EN <= r.m != SM_PSAVE;
            repeat (10) @(posedge REF_CLK);
            #1;
            chk(CORE_HALT, 1'b1);
            @(posedge REF_CLK);
            arm <= 1'b0;
            @(posedge REF_CLK);
            pat <= r.w;
            arm <= 1'b1;
            GLOBAL_IRQ_EN <= 1'b1;
            n = 0;
            repeat (100)
            begin
                @(posedge REF_CLK);
                #1;
                if (CORE_HALT === 1'b0)
                    break;
                if (WAKE_IN != 0 || EXTERNAL_INTERRUPT_ZERO_PIN_LEVEL || PIN_CHANGE_PIN)
                    n++;
            end
            chk(WAKE_IRQ, 1'b1);
            chk(n, r.n);
            @(posedge REF_CLK);
            arm <= 1'b0;
            $display("done: sleep mode %0d", r.m);
        end
        chk(CONV_EXTENDED, 1'b0);
        @(posedge REF_CLK);
        CONV_ENABLED <= 1'b0;
        COMP_USES_REF <= 1'b1;
        BOD_ENABLED <= 1'b0;
        WDT_ENABLED <= 1'b0;
        wr(GATE_OFS, 8'hff);
        chk({PERIPH_CLK_EN, PERIPH_REG_ACCESS}, 10'h000);
        rd(GATE_OFS, 8'h1f);
        chk({REF_POWER, BOD_POWER, WDT_POWER}, 3'b100);
        @(posedge REF_CLK);
        COMP_ENABLED <= 1'b0;
        TEST_PORT_ENABLE_FUSE <= 1'b0;
        wr(GATE_OFS, 8'h00);
        chk({PERIPH_CLK_EN, PERIPH_REG_ACCESS}, 10'h3ff);
        chk({REF_POWER, TEST_PORT_EN}, 2'b00);
        @(posedge REF_CLK);
        CONV_ENABLED <= 1'b1;
        repeat (3) @(posedge REF_CLK);
        #1;
        chk({CONV_EXTENDED, REF_POWER}, 2'b11);
        $display("done: gating and power");
        results();
    end
endmodule

`default_nettype wire
